/* prlc_regs.vh */
// Register offsets, field positions, reset values and timing counts for the ratio controller
`ifndef PRLC_REGS_VH
`define PRLC_REGS_VH
// Stored ratio bank: four 32-bit entries, four byte addresses each
`define PRLC_RATIO_BASE 8'h06
`define PRLC_RATIO_LAST 8'h15
// Configuration byte address (serial control port)
`define PRLC_CFG_ADDR 8'h03
`define PRLC_CFG2_ADDR 8'h04
`define PRLC_STAT_ADDR 8'h02
// Configuration fields in CFG_ADDR
`define PRLC_STATIC_PTR_LSB 6
`define PRLC_SCALER_LSB 3
`define PRLC_GAP_TOL_BIT 2
`define PRLC_OUT_UNL_BIT 1
// Configuration fields in CFG2_ADDR
`define PRLC_DYN_PTR_LSB 6
`define PRLC_FRAC_SRC_BIT 5
`define PRLC_FORMAT_BIT 4
`define PRLC_MIN_BW_LSB 0
// Reset values
`define PRLC_CFG_RESET 8'h00
`define PRLC_CFG2_RESET 8'h00
// Width in bits of the removal timeout counter (internal timing clock cycles)
`define PRLC_TIMEOUT_BITS 23
// Lock acquisition time in cycles
`define PRLC_ACQ_CYCLES 16'h0400
// Gap tolerance time in cycles
`define PRLC_GAP_CYCLES 23'h04E200
`endif

/* prlc_loss_det.v */
// Reference input loss detector: edge check, period watch and removal timeout
`timescale 1ns/1ps
module prlc_loss_det #(
  parameter [22:0] TIMEOUT_MAX = 23'h7FFFFF
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Synchronised reference input
  input wire ref_sync,
  // Status
  output reg ref_edge_q,
  output reg ref_present_q,
  output reg glitch_q,
  output reg timeout_q,
  output reg [22:0] gap_cnt_q
);
  reg ref_prev_q;
  reg [22:0] period_q;
  reg [22:0] run_q;
  wire edge_w = ref_sync & ~ref_prev_q;
  wire [22:0] slack_w = {3'h0, period_q[22:3]};
  // Late edge ends a gap; relearn the period before judging glitches
  wire late_w = ({1'b0, gap_cnt_q} > ({1'b0, period_q} + {1'b0, slack_w}));
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_prev_q <= 1'b0;
      ref_edge_q <= 1'b0;
      ref_present_q <= 1'b0;
      glitch_q <= 1'b0;
      timeout_q <= 1'b0;
      gap_cnt_q <= 23'h000000;
      period_q <= 23'h000000;
      run_q <= 23'h000000;
    end else begin
      ref_prev_q <= ref_sync;
      ref_edge_q <= edge_w;
      glitch_q <= 1'b0;
      if (edge_w) begin
        gap_cnt_q <= 23'h000000;
        timeout_q <= 1'b0;
        ref_present_q <= 1'b1;
        period_q <= gap_cnt_q;
        run_q <= late_w ? 23'h000000 : run_q + 23'h000001;
        if (ref_present_q && run_q > 23'h000002 &&
            (gap_cnt_q + slack_w) < period_q)
          glitch_q <= 1'b1;
      end else if (gap_cnt_q == TIMEOUT_MAX) begin
        timeout_q <= 1'b1;
        ref_present_q <= 1'b0;
        run_q <= 23'h000000;
      end else begin
        gap_cnt_q <= gap_cnt_q + 23'h000001;
      end
    end
  end
endmodule // prlc_loss_det

/* prlc_ctrl.v */
// Ratio selection and reference loss control for the clock synthesizer
// Summary of operation
// - Output continues for 2^23 timing clocks after the reference stops.
// - Glitch or period change during removal skips timeout, unlocks at once.
// - Clean timeout expiry unlocks; unlock setting then governs output pin.
// - Reference return after timeout: unlocked for acquisition time, then locked.
// - Gap tolerance off, short gap: unlocked only while reacquiring.
// - Gap tolerance on: output continuous, no unlock during short gap.
// - Three-bit field sets minimum loop bandwidth from 1 Hz to 128 Hz.
// - Wide bandwidth while acquiring, minimum bandwidth once locked.
// - Four stored 32-bit unsigned fixed-point ratio entries.
// - Static mode uses entry chosen by static pointer.
// - 12.20 format: 12-bit integer, 20-bit fraction.
// - Internal dividers compensated; stored ratio is output over input.
// - Hybrid mode uses entry chosen by dynamic pointer, same four entries.
// - 20.12 format: 20-bit integer, 12-bit fraction.
// - 20.12 only when format bit clear and dynamic source chosen.
// - Auto source with reference absent forces 12.20 format.
// - Modifier scales addressed ratio internally; stored entries unchanged.
// - Scaler codes 1,2,4,8,1/2,1/4,1/8,1/16; default code zero.
// - Modifier always applied to effective ratio, even factor one.
// - Auto source when pointers differ; manual source bit ignored then.
// - Output held low while unlocked unless output-while-unlocked set.
`timescale 1ns/1ps
`include "prlc_regs.vh"
module prlc_ctrl #(
  parameter [22:0] TIMEOUT_MAX = 23'h7FFFFF,
  parameter [15:0] ACQ_CYCLES = `PRLC_ACQ_CYCLES,
  parameter [22:0] GAP_CYCLES = `PRLC_GAP_CYCLES
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Register port
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  // Frequency reference input and synthesizer clock
  input wire ref_in,
  input wire synth_clk,
  // Synthesizer controls
  output reg clk_out_q,
  output reg locked_q,
  output reg dynamic_mode_q,
  output reg format_hi_mult_q,
  output reg [31:0] effective_ratio_q,
  output reg [2:0] loop_bw_q,
  output reg wide_bw_q
);
  localparam ST_LOCKED = 2'h0;
  localparam ST_HOLD = 2'h1;
  localparam ST_UNLOCKED = 2'h2;
  localparam ST_ACQUIRE = 2'h3;
  localparam [2:0] WIDE_BW_CODE = 3'h7;

  reg [31:0] stored_ratio_entries [0:3];
  reg [7:0] cfg_q;
  reg [7:0] cfg2_q;
  reg [1:0] state_q;
  reg [15:0] acq_cnt_q;
  reg skip_mode_q;
  reg [22:0] gap_len_q;
  reg ref_s1_q, ref_s2_q, syn_s1_q, syn_s2_q;
  wire ref_edge, ref_present, glitch, timeout;
  wire [22:0] gap_cnt;
  integer i;

  wire [1:0] static_ptr = cfg_q[`PRLC_STATIC_PTR_LSB+1:`PRLC_STATIC_PTR_LSB];
  wire [2:0] ratio_scaler_select = cfg_q[`PRLC_SCALER_LSB+2:`PRLC_SCALER_LSB];
  wire gap_tolerance_enable = cfg_q[`PRLC_GAP_TOL_BIT];
  wire output_while_unlocked = cfg_q[`PRLC_OUT_UNL_BIT];
  wire [1:0] dynamic_ratio_pointer = cfg2_q[`PRLC_DYN_PTR_LSB+1:`PRLC_DYN_PTR_LSB];
  wire fraction_source_select = cfg2_q[`PRLC_FRAC_SRC_BIT];
  wire ratio_format_select = cfg2_q[`PRLC_FORMAT_BIT];
  wire [2:0] min_loop_bandwidth_sel = cfg2_q[`PRLC_MIN_BW_LSB+2:`PRLC_MIN_BW_LSB];

  // Byte lane of a ratio address; entries stored big-endian
  function [4:0] ratio_slot;
    input [7:0] a;
    reg [7:0] off;
    begin
      off = a - `PRLC_RATIO_BASE;
      ratio_slot = off[4:0];
    end
  endfunction

  // Scale a ratio by the modifier code, shift only
  // Eight scaler codes
  function [31:0] apply_scaler;
    input [31:0] r;
    input [2:0] code;
    begin
      case (code)
        3'h0: apply_scaler = r;
        3'h1: apply_scaler = {r[30:0], 1'h0};
        3'h2: apply_scaler = {r[29:0], 2'h0};
        3'h3: apply_scaler = {r[28:0], 3'h0};
        3'h4: apply_scaler = {1'h0, r[31:1]};
        3'h5: apply_scaler = {2'h0, r[31:2]};
        3'h6: apply_scaler = {3'h0, r[31:3]};
        default: apply_scaler = {4'h0, r[31:4]};
      endcase
    end
  endfunction

  wire in_ratio = (reg_addr >= `PRLC_RATIO_BASE) && (reg_addr <= `PRLC_RATIO_LAST);
  wire [4:0] slot = ratio_slot(reg_addr);
  wire [1:0] wr_idx = slot[3:2];
  wire [1:0] wr_lane = slot[1:0];

  // Source selection
  // Pointers differ: auto
  wire auto_src = (dynamic_ratio_pointer != static_ptr);
  wire use_dynamic = auto_src ? ref_present : fraction_source_select;
  wire [1:0] sel_ptr = use_dynamic ? dynamic_ratio_pointer : static_ptr;
  wire [31:0] user_ratio = stored_ratio_entries[sel_ptr];
  wire hi_mult = ~ratio_format_select & use_dynamic;
  wire [31:0] effective_ratio = apply_scaler(user_ratio, ratio_scaler_select);

  // Reference and synthesizer clock synchronisers
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      syn_s1_q <= 1'b0;
      syn_s2_q <= 1'b0;
    end else begin
      ref_s1_q <= ref_in;
      ref_s2_q <= ref_s1_q;
      syn_s1_q <= synth_clk;
      syn_s2_q <= syn_s1_q;
    end
  end

  prlc_loss_det #(
    .TIMEOUT_MAX(TIMEOUT_MAX)
  ) u_loss (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ref_sync(ref_s2_q),
    .ref_edge_q(ref_edge),
    .ref_present_q(ref_present),
    .glitch_q(glitch),
    .timeout_q(timeout),
    .gap_cnt_q(gap_cnt)
  );

  // Register file; stored entries written only by software
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= `PRLC_CFG_RESET;
      cfg2_q <= `PRLC_CFG2_RESET;
      for (i = 0; i < 4; i = i + 1)
        stored_ratio_entries[i] <= 32'h00000000;
    end else if (reg_wr) begin
      if (reg_addr == `PRLC_CFG_ADDR)
        cfg_q <= reg_wdata;
      else if (reg_addr == `PRLC_CFG2_ADDR)
        cfg2_q <= reg_wdata;
      else if (in_ratio) begin
        case (wr_lane)
          2'h0: stored_ratio_entries[wr_idx][31:24] <= reg_wdata;
          2'h1: stored_ratio_entries[wr_idx][23:16] <= reg_wdata;
          2'h2: stored_ratio_entries[wr_idx][15:8] <= reg_wdata;
          default: stored_ratio_entries[wr_idx][7:0] <= reg_wdata;
        endcase
      end
    end
  end

  // Read data, registered
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_addr == `PRLC_CFG_ADDR) begin
      reg_rdata_q <= cfg_q;
    end else if (reg_addr == `PRLC_CFG2_ADDR) begin
      reg_rdata_q <= cfg2_q;
    end else if (reg_addr == `PRLC_STAT_ADDR) begin
      reg_rdata_q <= {4'h0, ref_present, skip_mode_q, state_q};
    end else if (in_ratio) begin
      case (wr_lane)
        2'h0: reg_rdata_q <= stored_ratio_entries[wr_idx][31:24];
        2'h1: reg_rdata_q <= stored_ratio_entries[wr_idx][23:16];
        2'h2: reg_rdata_q <= stored_ratio_entries[wr_idx][15:8];
        default: reg_rdata_q <= stored_ratio_entries[wr_idx][7:0];
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // Lock state machine
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_ACQUIRE;
      acq_cnt_q <= 16'h0000;
      skip_mode_q <= 1'b0;
      gap_len_q <= 23'h000000;
    end else begin
      // Gap length survives the edge that clears the counter
      gap_len_q <= gap_cnt;
      case (state_q)
        ST_LOCKED: begin
          skip_mode_q <= 1'b0;
          if (glitch) begin
            state_q <= ST_UNLOCKED;
          end else if (!ref_edge && gap_cnt > 23'h000100 && ref_present) begin
            state_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (glitch) begin
            state_q <= ST_UNLOCKED;
          end else if (timeout) begin
            state_q <= ST_UNLOCKED;
          end else if (ref_edge) begin
            acq_cnt_q <= 16'h0000;
            if (gap_tolerance_enable && gap_len_q <= GAP_CYCLES) begin
              skip_mode_q <= 1'b1;
              state_q <= ST_LOCKED;
            end else begin
              state_q <= ST_ACQUIRE;
            end
          end
        end
        ST_UNLOCKED: begin
          acq_cnt_q <= 16'h0000;
          if (ref_edge)
            state_q <= ST_ACQUIRE;
        end
        ST_ACQUIRE: begin
          if (glitch || timeout) begin
            state_q <= ST_UNLOCKED;
          end else if (acq_cnt_q == ACQ_CYCLES) begin
            state_q <= ST_LOCKED;
          end else begin
            acq_cnt_q <= acq_cnt_q + 16'h0001;
          end
        end
        default: state_q <= ST_UNLOCKED;
      endcase
    end
  end

  wire unlocked = (state_q == ST_UNLOCKED) || (state_q == ST_ACQUIRE);

  // Outputs to synthesizer
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_out_q <= 1'b0;
      locked_q <= 1'b0;
      dynamic_mode_q <= 1'b0;
      format_hi_mult_q <= 1'b0;
      effective_ratio_q <= 32'h00000000;
      loop_bw_q <= WIDE_BW_CODE;
      wide_bw_q <= 1'b1;
    end else begin
      clk_out_q <= syn_s2_q & (~unlocked | output_while_unlocked);
      locked_q <= ~unlocked;
      dynamic_mode_q <= use_dynamic;
      format_hi_mult_q <= hi_mult;
      effective_ratio_q <= effective_ratio;
      wide_bw_q <= unlocked;
      loop_bw_q <= unlocked ? WIDE_BW_CODE : min_loop_bandwidth_sel;
    end
  end
endmodule // prlc_ctrl

/* prlc_ctrl_assertions.sv */
// Port-level assertions for the ratio and reference loss controller
`timescale 1ns/1ps
module prlc_ctrl_checker #(
  parameter [22:0] TIMEOUT_MAX = 23'h7FFFFF,
  parameter [15:0] ACQ_CYCLES = 16'h0400
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Register port
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  // Reference and controls
  input wire ref_in,
  input wire locked_q,
  input wire dynamic_mode_q,
  input wire format_hi_mult_q,
  input wire [2:0] loop_bw_q,
  input wire wide_bw_q
);
  reg ref_q;
  reg [23:0] gap_q;
  reg [15:0] low_q;
  // Saturating counts so a long stop never wraps
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_q <= 1'b0;
      gap_q <= 24'h000000;
      low_q <= 16'h0000;
    end else begin
      ref_q <= ref_in;
      gap_q <= (ref_in && !ref_q) ? 24'h000000 : gap_q + {23'h000000, ~&gap_q};
      low_q <= locked_q ? 16'h0000 : low_q + {15'h0000, ~&low_q};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr; reg_wr && reg_addr >= 8'h06 && reg_addr <= 8'h15; endsequence
  sequence s_rd; !reg_wr && reg_addr == $past(reg_addr); endsequence
  property p_wr_rd; s_wr ##1 s_rd |=> reg_rdata_q == $past(reg_wdata, 2); endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("ratio byte readback wrong");
  property p_unmapped;
    (reg_addr < 8'h02 || reg_addr == 8'h05 || reg_addr > 8'h15) |=> reg_rdata_q == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_bw_wide; !locked_q && !$past(locked_q) |-> loop_bw_q == 3'h7 && wide_bw_q; endproperty
  a_bw_wide: assert property (p_bw_wide) else $error("narrow loop while unlocked");
  property p_bw_narrow; locked_q && $past(locked_q) |-> !wide_bw_q; endproperty
  a_bw_narrow: assert property (p_bw_narrow) else $error("wide loop while locked");
  property p_fmt; format_hi_mult_q |-> dynamic_mode_q; endproperty
  a_fmt: assert property (p_fmt) else $error("20.12 outside dynamic mode");
  property p_hold;
    $fell(locked_q) && gap_q > 24'd300 |-> gap_q >= TIMEOUT_MAX && gap_q <= TIMEOUT_MAX + 24'd10;
  endproperty
  a_hold: assert property (p_hold) else $error("lock lost off the timeout");
  property p_expire; gap_q == TIMEOUT_MAX + 24'd12 |-> !locked_q; endproperty
  a_expire: assert property (p_expire) else $error("still locked after timeout");
  property p_acq; $rose(locked_q) |-> low_q >= ACQ_CYCLES; endproperty
  a_acq: assert property (p_acq) else $error("lock regained too soon");
endmodule // prlc_ctrl_checker
bind prlc_ctrl prlc_ctrl_checker #(.TIMEOUT_MAX(TIMEOUT_MAX), .ACQ_CYCLES(ACQ_CYCLES)) chk_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .ref_in(ref_in), .locked_q(locked_q),
  .dynamic_mode_q(dynamic_mode_q), .format_hi_mult_q(format_hi_mult_q),
  .loop_bw_q(loop_bw_q), .wide_bw_q(wide_bw_q));

/* prlc_ref_model.sv */
// Reference clock source that may stop or glitch
`timescale 1ns/1ps
module prlc_ref_model #(
  parameter int HALF_NS = 128
) (
  // Control
  input wire run,
  input wire glitch,
  // Reference pin
  output logic ref_out
);
  initial ref_out = 1'b0;
  // Stands low while stopped
  always begin
    #(HALF_NS);
    ref_out = run ? ~ref_out : 1'b0;
  end
  // Short extra pulse, far below one period
  always @(posedge glitch) begin
    ref_out = 1'b0;
    #12 ref_out = 1'b1;
    #12 ref_out = 1'b0;
  end
endmodule // prlc_ref_model

/* tb_top.sv */
// Self-checking bench for the ratio controller
`timescale 1ns/1ps
`include "prlc_regs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  localparam [22:0] TO = 23'h000FFF;
  localparam [15:0] ACQ = 16'h0010;
  reg sys_clk = 0, rst_b = 0, reg_wr = 0, synth_clk = 0, run = 1, glitch = 0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [7:0] reg_rdata_q;
  wire ref_in, clk_out_q, locked_q, dynamic_mode_q, format_hi_mult_q, wide_bw_q;
  wire [31:0] effective_ratio_q;
  wire [2:0] loop_bw_q;
  int num_errors = 0, total_checks = 0, n;
  logic m;
  reg [31:0] v;
  logic [31:0] ent [4] = '{32'h00100000, 32'h00200000, 32'h00400000, 32'h00800000};
  // No row overflows
  // Rows: pointer, scaler code, expected effective ratio
  logic [36:0] rows [8] = '{{2'd0, 3'd0, 32'h00100000}, {2'd1, 3'd1, 32'h00400000},
    {2'd2, 3'd2, 32'h01000000}, {2'd3, 3'd3, 32'h04000000}, {2'd0, 3'd4, 32'h00080000},
    {2'd1, 3'd5, 32'h00080000}, {2'd2, 3'd6, 32'h00080000}, {2'd3, 3'd7, 32'h00080000}};
  always #2 sys_clk = ~sys_clk;
  always #40 synth_clk = ~synth_clk;
  prlc_ref_model prlc_ref_model_inst (.run(run), .glitch(glitch), .ref_out(ref_in));
  prlc_ctrl #(.TIMEOUT_MAX(TO), .ACQ_CYCLES(ACQ), .GAP_CYCLES(23'h000200)) prlc_ctrl_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .ref_in(ref_in), .synth_clk(synth_clk),
    .clk_out_q(clk_out_q), .locked_q(locked_q), .dynamic_mode_q(dynamic_mode_q),
    .format_hi_mult_q(format_hi_mult_q), .effective_ratio_q(effective_ratio_q),
    .loop_bw_q(loop_bw_q), .wide_bw_q(wide_bw_q));
  task results;
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    d = reg_rdata_q;
  endtask
  task wr32(input [1:0] e, input [31:0] x);
    for (int i = 0; i < 4; i++) wr(8'(8'h06 + 4 * e + i), x[31 - 8 * i -: 8]);
  endtask
  // Least significant byte first, so it follows the last write
  task rd32(input [1:0] e, output [31:0] x);
    reg [7:0] b;
    for (int i = 3; i >= 0; i--) begin
      rd(8'(8'h06 + 4 * e + i), b);
      x = {b, x[31:8]};
    end
  endtask
  task settle;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task till(input logic val, input int max, output int c);
    c = 0;
    while (locked_q !== val) begin
      @(negedge sys_clk);
      c++;
      if (c > max) begin
        num_errors++;
        results;
      end
    end
  endtask
  task watch(input int k, output int c, output logic lk);
    c = 0;
    lk = 1'b1;
    repeat (k) begin
      @(negedge sys_clk);
      lk &= locked_q;
      c += clk_out_q;
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    `CHK(loop_bw_q, 3'h7)
    `CHK(wide_bw_q, 1'b1)
    rst_b <= 1'b1;
    rd(`PRLC_CFG_ADDR, v[7:0]);
    `CHK(v[7:0], 8'h00)
    rd(`PRLC_CFG2_ADDR, v[7:0]);
    `CHK(v[7:0], 8'h00)
    wr(8'h05, 8'hA5);
    rd(8'h05, v[7:0]);
    `CHK(v[7:0], 8'h00)
    for (int e = 0; e < 4; e++) wr32(2'(e), ent[e]);
    rd32(2'd3, v);
    `CHK(v, ent[3])
    till(1'b1, 3000, n);
    foreach (rows[i]) begin
      wr(`PRLC_CFG_ADDR, {rows[i][36:32], 3'b000});
      wr(`PRLC_CFG2_ADDR, {rows[i][36:35], 6'h05});
      settle;
      `CHK(effective_ratio_q, rows[i][31:0])
      `CHK({dynamic_mode_q, format_hi_mult_q}, 2'b00)
    end
    rd32(2'd1, v);
    `CHK(v, ent[1])
    till(1'b1, 400, n);
    settle;
    `CHK({loop_bw_q, wide_bw_q}, 4'hA)
    wr(`PRLC_CFG_ADDR, 8'h00);
    wr(`PRLC_CFG2_ADDR, 8'h25);
    settle;
    `CHK({dynamic_mode_q, format_hi_mult_q}, 2'b11)
    `CHK(effective_ratio_q, ent[0])
    wr(`PRLC_CFG2_ADDR, 8'h35);
    settle;
    `CHK(format_hi_mult_q, 1'b0)
    wr(`PRLC_CFG2_ADDR, 8'h45);
    settle;
    `CHK({dynamic_mode_q, format_hi_mult_q}, 2'b11)
    `CHK(effective_ratio_q, ent[1])
    till(1'b1, 400, n);
    wr(`PRLC_CFG_ADDR, 8'h04);
    @(posedge sys_clk) run <= 1'b0;
    watch(300, n, m);
    @(posedge sys_clk) run <= 1'b1;
    `CHK(m, 1'b1)
    watch(200, n, m);
    `CHK(m, 1'b1)
    @(posedge sys_clk) run <= 1'b0;
    watch(700, n, m);
    @(posedge sys_clk) run <= 1'b1;
    `CHK(m, 1'b1)
    till(1'b0, 300, n);
    `CHK(n < 300, 1'b1)
    till(1'b1, 400, n);
    wr(`PRLC_CFG_ADDR, 8'h00);
    @(posedge sys_clk) run <= 1'b0;
    watch(300, n, m);
    @(posedge sys_clk) run <= 1'b1;
    `CHK(m, 1'b1)
    till(1'b0, 300, n);
    till(1'b1, 400, n);
    watch(200, n, m);
    // Glitch lands just after a real rising edge
    n = 0;
    while (ref_in !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    while (ref_in !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      results;
    end
    repeat (4) @(posedge sys_clk);
    glitch <= 1'b1;
    @(posedge sys_clk) glitch <= 1'b0;
    till(1'b0, 60, n);
    `CHK(n < 60, 1'b1)
    till(1'b1, 400, n);
    @(posedge sys_clk) run <= 1'b0;
    till(1'b0, 6000, n);
    `CHK(n >= TO - 70 && n <= TO + 10, 1'b1)
    settle;
    `CHK({dynamic_mode_q, format_hi_mult_q}, 2'b00)
    `CHK(effective_ratio_q, ent[0])
    watch(200, n, m);
    `CHK(n, 0)
    wr(`PRLC_CFG_ADDR, 8'h02);
    watch(200, n, m);
    `CHK({n > 0, m}, 2'b10)
    @(posedge sys_clk) run <= 1'b1;
    till(1'b1, 600, n);
    `CHK(n >= ACQ, 1'b1)
    results;
  end
endmodule // tb_top
